// [hdl/urxs_sampler.sv]
// Local design decisions: the Avalon-MM register port and the register offsets.
`timescale 1ns/10ps
`include "urxs_defs.svh"

// How it works
// R1 - One bit period is 8 or 16 component clocks, chosen by software.
// R2 - In 8x without voting the bit is sampled on the fourth clock.
// R3 - A falling edge on idle RX starts a frame and restarts counters.
// R4 - Start midpoint checked three clocks after restart, then every bit period.
// R5 - Frame timing begins at the first clock edge after the edge is seen.
// R6 - With voting, three samples one clock apart, majority decides the bit.
// R7 - Optional second stop bit is checked before the receiver rearms.
// R8 - In 16x mode the same scheme scales to sixteen clocks per bit.
// R9 - Low stop sample flags framing error; rearm only after RX returns high.
module urxs_sampler
    import urxs_pkg::*;
#(
    parameter int DATA_BITS = 8
)(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        rx,
    input  wire logic [4:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    output logic             irq
);
    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (DATA_BITS < 5 || DATA_BITS > 9) begin : badDataBits
        $error("DATA_BITS must be 5 to 9");
    end

    localparam logic [3:0] LAST_BIT = 4'(DATA_BITS - 1);

    urxs_state_e             state_r;
    logic                    rxQ_r;
    logic                    rxPrev_r;
    logic [3:0]              ctrl_r;
    logic                    os16Cfg_r;
    logic                    voteCfg_r;
    logic                    stop2Cfg_r;
    logic [3:0]              bitIdx_r;
    logic [DATA_BITS-1:0]    shReg_r;
    logic [DATA_BITS-1:0]    rxData_r;
    logic                    full_r;
    logic [`URXS_EVT_W-1:0]  stat_r;
    logic [`URXS_EVT_W-1:0]  mask_r;
    logic [31:0]             readdata_r;
    logic                    waitrequest_r;
    logic                    irq_r;
    urxs_cnt_t               cnt;
    logic                    decTick;
    logic                    midBit;
    logic                    voteBit;

    // ------------------------------------------------------------
    // Line register and edge detect
    // ------------------------------------------------------------
    // One flop on RX gives the single clock of start uncertainty
    always_ff @(posedge clk) begin
        if (rst) begin
            rxQ_r    <= 1'b1;
            rxPrev_r <= 1'b1;
        end else begin
            rxQ_r    <= rx;
            rxPrev_r <= rxQ_r;
        end
    end

    wire enabled  = ctrl_r[`URXS_CTRL_EN];
    wire fallSeen = rxPrev_r & ~rxQ_r;
    wire startDet = (state_r == URXS_IDLE) && enabled && fallSeen; // R3
    wire bitVal   = voteCfg_r ? voteBit : midBit;                  // R6 R2

    // ------------------------------------------------------------
    // Timing and voting helpers
    // ------------------------------------------------------------
    urxs_bit_timer uTimer (
        .clk     (clk),
        .rst     (rst),
        .restart (startDet),
        .os16    (os16Cfg_r),
        .cnt     (cnt),
        .decTick (decTick)
    );

    urxs_voter uVoter (
        .clk     (clk),
        .rst     (rst),
        .rxIn    (rxQ_r),
        .midBit  (midBit),
        .voteBit (voteBit)
    );

    // ------------------------------------------------------------
    // Frame sequencer decode
    // ------------------------------------------------------------
    wire inStart   = (state_r == URXS_START) && decTick;
    wire inData    = (state_r == URXS_DATA) && decTick;
    wire inStop    = (state_r == URXS_STOP) && decTick;
    wire inStop2   = (state_r == URXS_STOP2) && decTick;
    wire stopBad   = (inStop || inStop2) && !bitVal;
    wire deliver   = inStop && bitVal;
    wire lastData  = inData && (bitIdx_r == LAST_BIT);

    urxs_state_e stateNxt;
    always_comb begin
        stateNxt = state_r;
        case (state_r)
            URXS_IDLE: begin
                if (startDet) begin
                    stateNxt = URXS_START; // R3 R5
                end
            end
            URXS_START: begin
                if (inStart) begin
                    stateNxt = bitVal ? URXS_IDLE : URXS_DATA; // R4
                end
            end
            URXS_DATA: begin
                if (lastData) begin
                    stateNxt = URXS_STOP;
                end
            end
            URXS_STOP: begin
                if (stopBad) begin
                    stateNxt = URXS_WAITH; // R9
                end else if (inStop) begin
                    stateNxt = stop2Cfg_r ? URXS_STOP2 : URXS_IDLE; // R7
                end
            end
            URXS_STOP2: begin
                if (stopBad) begin
                    stateNxt = URXS_WAITH;
                end else if (inStop2) begin
                    stateNxt = URXS_IDLE;
                end
            end
            URXS_WAITH: begin
                if (rxQ_r) begin
                    stateNxt = URXS_IDLE; // R9
                end
            end
            default: begin
                stateNxt = URXS_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Sequencer and shift register
    // ------------------------------------------------------------
    // Mode is latched at the start edge; a mid-frame write cannot skew bits
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r    <= URXS_IDLE;
            bitIdx_r   <= 4'h0;
            shReg_r    <= '0;
            os16Cfg_r  <= 1'b0;
            voteCfg_r  <= 1'b0;
            stop2Cfg_r <= 1'b0;
        end else begin
            state_r <= stateNxt;
            if (state_r == URXS_IDLE) begin
                os16Cfg_r  <= ctrl_r[`URXS_CTRL_OS16]; // R1 R8
                voteCfg_r  <= ctrl_r[`URXS_CTRL_VOTE];
                stop2Cfg_r <= ctrl_r[`URXS_CTRL_STOP2];
                bitIdx_r   <= 4'h0;
            end
            if (inData) begin
                shReg_r  <= {bitVal, shReg_r[DATA_BITS-1:1]}; // LSB first
                bitIdx_r <= bitIdx_r + 4'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire accept  = (read || write) && !waitrequest_r;
    wire wrAcc   = write && accept;
    wire rdAcc   = read && accept;
    wire selCtrl = (address == `URXS_OFF_CTRL);
    wire selStat = (address == `URXS_OFF_STAT);
    wire selMask = (address == `URXS_OFF_MASK);
    wire selData = (address == `URXS_OFF_DATA);
    wire dataRd  = rdAcc && selData;

    wire [`URXS_EVT_W-1:0] evtSet = {deliver && full_r && !dataRd, stopBad, deliver};
    wire [`URXS_EVT_W-1:0] evtClr = (wrAcc && selStat) ? writedata[`URXS_EVT_W-1:0] : '0;
    wire [`URXS_EVT_W-1:0] statNxt = (stat_r & ~evtClr) | evtSet;

    wire [31:0] statWord = {26'h0, full_r, state_r != URXS_IDLE, 1'b0, stat_r};
    wire [31:0] rdMux    = selCtrl ? {28'h0, ctrl_r} :
                           selStat ? statWord :
                           selMask ? {29'h0, mask_r} :
                           selData ? 32'(rxData_r) : 32'h0;

    // ------------------------------------------------------------
    // Registers and received data
    // ------------------------------------------------------------
    // Set beats clear so an event in the clearing cycle is kept
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_r   <= `URXS_CTRL_RST;
            mask_r   <= '0;
            stat_r   <= '0;
            rxData_r <= '0;
            full_r   <= 1'b0;
        end else begin
            stat_r <= statNxt;
            if (wrAcc && selCtrl) begin
                ctrl_r <= writedata[3:0];
            end
            if (wrAcc && selMask) begin
                mask_r <= writedata[`URXS_EVT_W-1:0];
            end
            if (deliver) begin
                rxData_r <= shReg_r;
                full_r   <= 1'b1;
            end else if (dataRd) begin
                full_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Bus answer and interrupt
    // ------------------------------------------------------------
    // One wait state per access; waitrequest idles high
    always_ff @(posedge clk) begin
        if (rst) begin
            waitrequest_r <= 1'b1;
            readdata_r    <= 32'h0;
            irq_r         <= 1'b0;
        end else begin
            waitrequest_r <= !((read || write) && waitrequest_r);
            if (read && waitrequest_r) begin
                readdata_r <= rdMux;
            end
            irq_r <= |(statNxt & mask_r);
        end
    end

    assign readdata    = readdata_r;
    assign waitrequest = waitrequest_r;
    assign irq         = irq_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    start_restart_a: assert property ( // R3
        startDet |=> state_r == URXS_START && cnt == 4'h0
    ) else $error("start edge did not restart the counters");

    first_edge_a: assert property ( // R5
        $rose(state_r == URXS_START) |-> $past(fallSeen) && cnt == 4'h0
    ) else $error("frame timing did not begin on the next edge");

    start_mid_a: assert property ( // R4
        (startDet && !os16Cfg_r) |=> ##3 cnt == `URXS_HALF8 ##1 decTick
    ) else $error("start midpoint not three clocks after restart");

    period8_a: assert property ( // R1
        (inData && !os16Cfg_r) |-> ##8 decTick
    ) else $error("8x bit period is not eight clocks");

    period16_a: assert property ( // R8
        (inData && os16Cfg_r) |=> !decTick [*8] ##8 decTick
    ) else $error("16x bit period is not sixteen clocks");

    fourth_clk_a: assert property ( // R2
        (inData && !os16Cfg_r && !voteCfg_r) |-> $past(cnt) == 4'h3 && bitVal == $past(rxQ_r)
    ) else $error("8x sample not taken on the fourth clock");

    vote_major_a: assert property ( // R6
        (inData && voteCfg_r) |=> shReg_r[DATA_BITS-1] ==
            (($past(rxQ_r, 3) & $past(rxQ_r, 2)) | ($past(rxQ_r, 3) & $past(rxQ_r))
            | ($past(rxQ_r, 2) & $past(rxQ_r)))
    ) else $error("voted bit is not the majority of three samples");

    two_stop_a: assert property ( // R7
        (inStop && bitVal && stop2Cfg_r) |=> state_r == URXS_STOP2
    ) else $error("second stop bit was skipped");

    frame_err_a: assert property ( // R9
        (inStop && !bitVal) |=> state_r == URXS_WAITH && stat_r[`URXS_ST_FERR]
    ) else $error("low stop bit did not flag a framing error");

    wait_high_a: assert property ( // R9
        (state_r == URXS_WAITH && !rxQ_r) |=> state_r == URXS_WAITH
    ) else $error("rearmed before the line returned high");

    bus_answer_a: assert property (
        ((read || write) && waitrequest_r) |=> !waitrequest_r ##1 waitrequest_r
    ) else $error("bus answer not exactly one wait state");

    start_mid16_a: assert property ( // R8
        (startDet && os16Cfg_r) |=> ##7 cnt == `URXS_HALF16 ##1 decTick
    ) else $error("16x start midpoint not seven clocks after restart");

    false_start_a: assert property ( // R4
        (inStart && bitVal) |=> state_r == URXS_IDLE
    ) else $error("high start midpoint did not abandon the frame");

    disabled_idle_a: assert property ( // R3
        (state_r == URXS_IDLE && !enabled) |=> state_r == URXS_IDLE
    ) else $error("frame started while the receiver was disabled");

    // Mode bits must not move under a running frame
    mode_hold_a: assert property ( // R1
        (state_r != URXS_IDLE) |=> $stable(os16Cfg_r) && $stable(voteCfg_r)
            && $stable(stop2Cfg_r)
    ) else $error("frame mode changed in mid-frame");

    // ------------------------------------------------------------
    // Status, data and interrupt checks
    // ------------------------------------------------------------
    data_load_a: assert property (
        deliver |=> full_r && rxData_r == $past(shReg_r) && stat_r[`URXS_ST_DONE]
    ) else $error("received word not delivered");

    read_clear_a: assert property (
        (dataRd && !deliver) |=> !full_r
    ) else $error("data read did not clear the full flag");

    overrun_flag_a: assert property (
        (deliver && full_r && !dataRd) |=> stat_r[`URXS_ST_OVR]
    ) else $error("overrun not flagged");

    // A clear in the same cycle as the event must not hide it
    set_wins_a: assert property ( // R9
        (stopBad && wrAcc && selStat && writedata[`URXS_ST_FERR]) |=> stat_r[`URXS_ST_FERR]
    ) else $error("framing error lost to a same-cycle clear");

    irq_level_a: assert property (
        irq_r == |(stat_r & $past(mask_r))
    ) else $error("interrupt level does not follow masked status");

    byte_cov: cover property (deliver);
    vote16_cov: cover property (inStop && voteCfg_r && os16Cfg_r);
    ferr_cov: cover property (stopBad);
    false_start_cov: cover property (inStart && bitVal);
endmodule

// [inc/urxs_defs.svh]
`ifndef URXS_DEFS_SVH
`define URXS_DEFS_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define URXS_OFF_CTRL   5'h00
`define URXS_OFF_STAT   5'h04
`define URXS_OFF_MASK   5'h08
`define URXS_OFF_DATA   5'h0c

// ------------------------------------------------------------
// Control fields
// ------------------------------------------------------------
`define URXS_CTRL_EN    0
`define URXS_CTRL_OS16  1
`define URXS_CTRL_VOTE  2
`define URXS_CTRL_STOP2 3
`define URXS_CTRL_RST   4'h1

// ------------------------------------------------------------
// Status fields; low three are sticky events
// ------------------------------------------------------------
`define URXS_ST_DONE    0
`define URXS_ST_FERR    1
`define URXS_ST_OVR     2
`define URXS_ST_BUSY    4
`define URXS_ST_FULL    5
`define URXS_EVT_W      3

// ------------------------------------------------------------
// Clock period in ns and bit timing in component clocks
// ------------------------------------------------------------
`define URXS_CLK_NS     40
`define URXS_LAST8      4'h7
`define URXS_LAST16     4'hf
`define URXS_HALF8      4'h3
`define URXS_HALF16     4'h7

`endif

// [inc/urxs_pkg.sv]
package urxs_pkg;

    typedef enum logic [2:0] {
        URXS_IDLE  = 3'b000,
        URXS_START = 3'b001,
        URXS_DATA  = 3'b010,
        URXS_STOP  = 3'b011,
        URXS_STOP2 = 3'b100,
        URXS_WAITH = 3'b101
    } urxs_state_e;

    typedef logic [3:0] urxs_cnt_t;

endpackage

// [hdl/urxs_bit_timer.sv]
`timescale 1ns/10ps
`include "urxs_defs.svh"

// Oversampling counter: one bit period is 8 or 16 clocks
module urxs_bit_timer
    import urxs_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      rst,
    input  wire logic      restart,
    input  wire logic      os16,
    output urxs_cnt_t      cnt,
    output wire logic      decTick
);
    urxs_cnt_t cnt_r;
    wire urxs_cnt_t lastCnt = os16 ? `URXS_LAST16 : `URXS_LAST8;
    wire urxs_cnt_t halfCnt = os16 ? `URXS_HALF16 : `URXS_HALF8;

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    // Restart wins so a frame always aligns to its own start edge
    always_ff @(posedge clk) begin
        if (rst || restart || cnt_r == lastCnt) begin
            cnt_r <= 4'h0;
        end else begin
            cnt_r <= cnt_r + 4'h1;
        end
    end

    assign cnt     = cnt_r;
    // Decision one clock after mid, so the late vote sample exists
    assign decTick = (cnt_r == halfCnt + 4'h1);
endmodule

// [hdl/urxs_voter.sv]
`timescale 1ns/10ps

// Two-sample history and two-out-of-three majority with the live sample
module urxs_voter (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic rxIn,
    output wire logic midBit,
    output wire logic voteBit
);
    logic [1:0] hist_r;

    // ------------------------------------------------------------
    // History of the two previous line samples
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            hist_r <= 2'b11;
        end else begin
            hist_r <= {hist_r[0], rxIn};
        end
    end

    // Sample at mid is one clock old at decision time
    assign midBit  = hist_r[0];
    assign voteBit = (hist_r[1] & hist_r[0]) | (hist_r[1] & rxIn) | (hist_r[0] & rxIn);
endmodule

// [verif/urxs_line_driver.sv]
`timescale 1ns/10ps

// Remote transmitter on the serial line; the line idles high as with a pull-up
module urxs_line_driver (
    input  wire logic clk,
    output logic      rx
);
    initial rx = 1'b1;

    // -----------------------------------------------------------
    // Frame sender
    // -----------------------------------------------------------
    // Bit index 0 is start, 1..8 data LSB first, then stops[0], stops[1].
    // Glitch inverts one clock of every data bit; a negative position means none.
    task automatic send(input logic [7:0] d, input int per, input int nStop,
                        input logic [1:0] stops, input int glitch);
        logic [10:0] bits;
        bits = {stops, d, 1'b0};
        for (int b = 0; b < 9 + nStop; b++) begin
            for (int c = 0; c < per; c++) begin
                @(posedge clk);
                rx <= (b >= 1 && b <= 8 && c == glitch) ? ~bits[b] : bits[b];
            end
        end
        // Idle gap high so a failed stop can rearm the receiver
        repeat (per) begin
            @(posedge clk);
            rx <= 1'b1;
        end
    endtask

    // Short low pulse, gone before the start midpoint; then idle high
    task automatic blip(input int lowClks, input int gap);
        repeat (lowClks) begin
            @(posedge clk);
            rx <= 1'b0;
        end
        repeat (gap) begin
            @(posedge clk);
            rx <= 1'b1;
        end
    endtask
endmodule

// [verif/urxs_sampler_bench.sv]
`timescale 1ns/10ps
`include "urxs_defs.svh"

module urxs_sampler_bench;
    logic        clk;
    logic        rst;
    logic        rx;
    logic [4:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        irq;
    logic [31:0] rd;
    int          nMismatch;
    int          checkCount;

    urxs_sampler #(.DATA_BITS(8)) u_urxs_sampler (
        .clk         (clk),
        .rst         (rst),
        .rx          (rx),
        .address     (address),
        .read        (read),
        .write       (write),
        .writedata   (writedata),
        .readdata    (readdata),
        .waitrequest (waitrequest),
        .irq         (irq)
    );

    urxs_line_driver u_urxs_line_driver (
        .clk (clk),
        .rx  (rx)
    );

    // Free-running 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // -----------------------------------------------------------
    // Helper tasks
    // -----------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            nMismatch++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // One bus cycle; held until waitrequest is sampled low, bounded wait
    task automatic busAccess(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        address   <= a;
        writedata <= d;
        write     <= wr;
        read      <= ~wr;
        @(posedge clk);
        while (waitrequest !== 1'b0 && n < 50) begin
            n++;
            @(posedge clk);
        end
        if (n >= 50) begin
            nMismatch++;
            $display("mismatch at %0t: bus answer never came", $time);
            tally_and_finish();
        end else begin
            rd = readdata;
            read  <= 1'b0;
            write <= 1'b0;
        end
    endtask

    task automatic wrReg(input logic [4:0] a, input logic [31:0] d);
        busAccess(1'b1, a, d);
    endtask

    task automatic rdReg(input logic [4:0] a);
        busAccess(1'b0, a, 32'h0);
    endtask

    task automatic frame(input logic [7:0] d, input int per, input int nStop,
                         input logic [1:0] stops, input int glitch);
        u_urxs_line_driver.send(d, per, nStop, stops, glitch);
    endtask

    task automatic irqIs(input logic exp);
        repeat (2) @(posedge clk);
        check({31'h0, irq}, {31'h0, exp});
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checkCount, nMismatch);
        if (nMismatch == 0 && checkCount > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Watchdog; the whole run needs well under two thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        nMismatch++;
        $display("mismatch at %0t: watchdog expired", $time);
        tally_and_finish();
    end

    // -----------------------------------------------------------
    // Test sequence
    // -----------------------------------------------------------
    initial begin
        rst = 1'b1;
        address = 5'h00;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        nMismatch = 0;
        checkCount = 0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        // Reset values, unmapped address, read-only and reserved bits
        rdReg(`URXS_OFF_CTRL); check(rd, 32'h1);
        rdReg(`URXS_OFF_STAT); check(rd, 32'h0);
        rdReg(`URXS_OFF_MASK); check(rd, 32'h0);
        rdReg(`URXS_OFF_DATA); check(rd, 32'h0);
        rdReg(5'h10);          check(rd, 32'h0);
        wrReg(`URXS_OFF_CTRL, 32'hff); rdReg(`URXS_OFF_CTRL); check(rd, 32'hf);
        wrReg(`URXS_OFF_MASK, 32'hff); rdReg(`URXS_OFF_MASK); check(rd, 32'h7);
        wrReg(`URXS_OFF_DATA, 32'h55); rdReg(`URXS_OFF_DATA); check(rd, 32'h0);
        // Disabled receiver ignores a whole frame
        wrReg(`URXS_OFF_CTRL, 32'h0);
        frame(8'h99, 8, 1, 2'b11, -1);
        rdReg(`URXS_OFF_STAT); check(rd, 32'h0);
        // 8x, no vote; glitch on first clock of each data bit must miss the sample
        wrReg(`URXS_OFF_CTRL, 32'h1);
        wrReg(`URXS_OFF_MASK, 32'h1);
        // A two-clock low pulse is a false start and leaves no trace
        u_urxs_line_driver.blip(2, 16);
        rdReg(`URXS_OFF_STAT); check(rd, 32'h0);
        irqIs(1'b0);
        frame(8'ha5, 8, 1, 2'b11, 0);
        rdReg(`URXS_OFF_STAT); check(rd, 32'h21);
        irqIs(1'b1);
        rdReg(`URXS_OFF_DATA); check(rd, 32'ha5);
        rdReg(`URXS_OFF_STAT); check(rd, 32'h1);
        wrReg(`URXS_OFF_STAT, 32'h1);
        irqIs(1'b0);
        // Overrun with the interrupt masked off
        wrReg(`URXS_OFF_MASK, 32'h0);
        frame(8'h3c, 8, 1, 2'b11, -1);
        frame(8'hc3, 8, 1, 2'b11, -1);
        rdReg(`URXS_OFF_STAT); check(rd, 32'h25);
        irqIs(1'b0);
        rdReg(`URXS_OFF_DATA); check(rd, 32'hc3);
        wrReg(`URXS_OFF_STAT, 32'h7);
        // Low stop bit, then a clean frame after the line rearms
        frame(8'h0f, 8, 1, 2'b00, -1);
        rdReg(`URXS_OFF_STAT); check(rd & 32'h2, 32'h2);
        wrReg(`URXS_OFF_STAT, 32'h7);
        frame(8'h81, 8, 1, 2'b11, -1);
        rdReg(`URXS_OFF_STAT); check(rd & 32'h3, 32'h1);
        rdReg(`URXS_OFF_DATA); check(rd, 32'h81);
        // Voting outvotes a one-clock glitch at the midpoint
        wrReg(`URXS_OFF_CTRL, 32'h5);
        frame(8'h6d, 8, 1, 2'b11, 4);
        rdReg(`URXS_OFF_DATA); check(rd, 32'h6d);
        // Two stop bits: good frame, then second stop low
        wrReg(`URXS_OFF_CTRL, 32'h9);
        wrReg(`URXS_OFF_STAT, 32'h7);
        frame(8'h12, 8, 2, 2'b11, -1);
        rdReg(`URXS_OFF_STAT); check(rd & 32'h3, 32'h1);
        rdReg(`URXS_OFF_DATA); check(rd, 32'h12);
        frame(8'h34, 8, 2, 2'b01, -1);
        rdReg(`URXS_OFF_STAT); check(rd & 32'h2, 32'h2);
        wrReg(`URXS_OFF_STAT, 32'h7);
        // 16x without and with voting
        wrReg(`URXS_OFF_CTRL, 32'h3);
        frame(8'he7, 16, 1, 2'b11, 0);
        rdReg(`URXS_OFF_DATA); check(rd, 32'he7);
        wrReg(`URXS_OFF_CTRL, 32'h7);
        frame(8'h5a, 16, 1, 2'b11, 8);
        rdReg(`URXS_OFF_DATA); check(rd, 32'h5a);
        rdReg(`URXS_OFF_STAT); check(rd & 32'h12, 32'h0);
        tally_and_finish();
    end
endmodule
